// file: design/txrsc_pkg.sv
// Shared constants, codes and state type of the transmit radio state control
package txrsc_pkg;
  // Crystal cycle counts for state transitions
  localparam logic [15:0] SET_PLAIN      = 16'h07A2;
  localparam logic [15:0] SET_CAL_BASE   = 16'h07A1;
  localparam logic [15:0] MAN_CAL_BASE   = 16'h011B;
  localparam logic [15:0] CAL_09_CP_OFF  = 16'h0EB4;
  localparam logic [15:0] CAL_0B_CP_OFF  = 16'h0FE9;
  localparam logic [15:0] WAKE_CYC       = 16'h0040;
  // Calibration and power-index selectors
  localparam logic [7:0]  CAL_TEST_0B    = 8'h0B;
  localparam logic [1:0]  CP_CAL_OFF     = 2'h0;
  localparam logic [2:0]  PWR_IDX_OOK    = 3'h1;
  // Strobe codes on the command port
  localparam logic [2:0]  STR_RES        = 3'h0;
  localparam logic [2:0]  STR_SYNTH_ON_TX_FREQ_STATE     = 3'h1;
  localparam logic [2:0]  STR_CRYSTAL_OFF_STATE       = 3'h2;
  localparam logic [2:0]  STR_CAL        = 3'h3;
  localparam logic [2:0]  STR_TX         = 3'h4;
  localparam logic [2:0]  STR_IDLE       = 3'h5;
  localparam logic [2:0]  STR_PWD        = 3'h6;
  localparam logic [2:0]  STR_FTX        = 3'h7;
  // Automatic calibration policies
  localparam logic [1:0]  POL_NEVER      = 2'h0;
  localparam logic [1:0]  POL_TO_TX      = 2'h1;
  localparam logic [1:0]  POL_FROM_TX    = 2'h2;
  localparam logic [1:0]  POL_FOURTH     = 2'h3;
  // Destinations after a packet
  localparam logic [1:0]  AFT_IDLE       = 2'h0;
  localparam logic [1:0]  AFT_SYNTH_ON_TX_FREQ_STATE     = 2'h1;
  localparam logic [1:0]  AFT_TX         = 2'h2;
  // Transmit FIFO sizing and threshold table
  localparam logic [6:0]  FIFO_DEPTH     = 7'h40;
  localparam logic [6:0]  THR_TOP        = 7'h3D;
  localparam logic [6:0]  THR_MIN        = 7'h01;
  localparam logic [3:0]  THR_SEL_LAST   = 4'hF;

  typedef enum logic [3:0] {
    ST_SLEEP, ST_CRYSTAL_OFF_STATE, ST_WAKE, ST_IDLE, ST_CAL,
    ST_SETTLE, ST_SYNTH_ON_TX_FREQ_STATE, ST_TX, ST_TXEND, ST_UFLOW
  } txrsc_state_t;

  // Threshold in bytes for a selector value
  function automatic logic [6:0] fifo_threshold_sel(input logic [3:0] sel);
    if (sel == THR_SEL_LAST) begin
      fifo_threshold_sel = THR_MIN;
    end else begin
      fifo_threshold_sel = THR_TOP - {1'b0, sel, 2'b00};
    end
  endfunction : fifo_threshold_sel
endpackage : txrsc_pkg

// file: design/txrsc_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module txrsc_sync (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic resetn_in,
  // Level in and out
  input  wire logic d_in,
  output var  logic q_out
);
  logic meta;

  // First stage feeds only the second
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta  <= 1'b0;
      q_out <= 1'b0;
    end else begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule : txrsc_sync
`default_nettype wire

// file: design/txrsc_fifo.sv
// 64-byte transmit FIFO with fill count
`timescale 1ns/10ps
`default_nettype none
module txrsc_fifo
  import txrsc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  // Fill side
  input  wire logic       wr_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic       flush_in,
  // Drain side
  input  wire logic       rd_in,
  output var  logic [7:0] rd_data_out,
  output var  logic       rd_valid_out,
  // Status
  output var  logic [6:0] count_out,
  output logic            empty_out
);
  logic [7:0] mem [0:63];
  logic [5:0] wptr;
  logic [5:0] rptr;
  wire        do_rd = rd_in & ~empty_out;

  assign empty_out = (count_out == 7'h00);

  // Storage; an overfilled FIFO simply overwrites unread bytes
  always_ff @(posedge clk_in) begin
    if (wr_in) begin
      mem[wptr] <= wr_data_in;
    end
  end

  // Pointers, count and read data
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wptr <= 6'h00;
      rptr <= 6'h00;
      count_out <= 7'h00;
      rd_data_out <= 8'h00;
      rd_valid_out <= 1'b0;
    end else if (flush_in) begin
      wptr <= 6'h00;
      rptr <= 6'h00;
      count_out <= 7'h00;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= do_rd;
      if (wr_in) begin
        wptr <= wptr + 6'h01;
      end
      if (do_rd) begin
        rptr <= rptr + 6'h01;
        rd_data_out <= mem[rptr];
      end
      if (wr_in && !do_rd && count_out != FIFO_DEPTH) begin
        count_out <= count_out + 7'h01;
      end else if (!wr_in && do_rd) begin
        count_out <= count_out - 7'h01;
      end
    end
  end
endmodule : txrsc_fifo
`default_nettype wire

// file: design/txrsc_ctrl.sv
// Radio state control: crystal, regulator, transmit states, calibration, TX FIFO
`timescale 1ns/10ps
`default_nettype none
module txrsc_ctrl #(
  parameter logic [15:0] CAL_09_CP_ON = 16'h484A,
  parameter logic [15:0] CAL_0B_CP_ON = 16'h497F
) (
  // Crystal clock and reset
  input  wire logic       mclk_in,
  input  wire logic       resetn_in,
  // Host link, on the serial clock
  input  wire logic       link_clk_in,
  input  wire logic       link_valid_in,
  input  wire logic       link_is_byte_in,
  input  wire logic [2:0] link_strobe_in,
  input  wire logic [7:0] link_data_in,
  output var  logic       link_busy_out,
  // Chip-select pin
  input  wire logic       chip_select_n_in,
  // Configuration
  input  wire logic       xosc_force_on_in,
  input  wire logic [1:0] auto_calibration_policy_in,
  input  wire logic [1:0] after_transmit_state_in,
  input  wire logic [7:0] calibration_test_value_in,
  input  wire logic [1:0] charge_pump_cal_enable_in,
  input  wire logic [2:0] power_index_select_in,
  input  wire logic [3:0] fifo_threshold_sel_in,
  input  wire logic [15:0] symbol_cycles_in,
  // Modulator side
  input  wire logic       mod_byte_req_in,
  input  wire logic       packet_done_in,
  output logic [7:0]      tx_byte_out,
  output logic            tx_byte_valid_out,
  output var  logic       tx_preamble_out,
  // Power and status
  output var  logic       xosc_enable_out,
  output var  logic       core_reg_enable_out,
  output var  logic       chip_ready_n_out,
  output var  logic       tx_active_out,
  output var  logic       synth_on_out,
  output var  logic       tx_underflow_out,
  output logic [6:0]      tx_fill_count_out,
  output var  logic       fifo_threshold_out
);
  import txrsc_pkg::*;

  // Link handshake registers of both clock domains and the synchronised chip-select
  logic       req;
  logic       hold_is_byte;
  logic [2:0] hold_code;
  logic [7:0] hold_data;
  logic       ack;
  logic       ack_s;
  logic       req_s;
  logic       req_seen;
  logic       cs_n_s;
  wire        accept = link_valid_in & ~link_busy_out;

  // Serial-clock side: one command in flight at a time
  always_ff @(posedge link_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      req <= 1'b0;
      link_busy_out <= 1'b0;
      hold_is_byte <= 1'b0;
      hold_code <= 3'h0;
      hold_data <= 8'h00;
    end else if (accept) begin
      req <= ~req;
      link_busy_out <= 1'b1;
      hold_is_byte <= link_is_byte_in;
      hold_code <= link_strobe_in;
      hold_data <= link_data_in;
    end else if (ack_s == req) begin
      link_busy_out <= 1'b0;
    end
  end

  // Crossings: request, acknowledge, chip-select
  txrsc_sync u_req_sync (
    .clk_in    (mclk_in),
    .resetn_in (resetn_in),
    .d_in      (req),
    .q_out     (req_s)
  );
  txrsc_sync u_ack_sync (
    .clk_in    (link_clk_in),
    .resetn_in (resetn_in),
    .d_in      (ack),
    .q_out     (ack_s)
  );
  txrsc_sync u_cs_sync (
    .clk_in    (mclk_in),
    .resetn_in (resetn_in),
    .d_in      (chip_select_n_in),
    .q_out     (cs_n_s)
  );

  // Command decode; hold registers are stable while the request is open
  wire cmd_pulse = req_s ^ req_seen;
  wire is_str    = cmd_pulse & ~hold_is_byte;
  wire fifo_wr   = cmd_pulse & hold_is_byte;
  wire s_res     = is_str & (hold_code == STR_RES);
  wire s_synth_on_tx_freq_state  = is_str & (hold_code == STR_SYNTH_ON_TX_FREQ_STATE);
  wire s_crystal_off_state    = is_str & (hold_code == STR_CRYSTAL_OFF_STATE);
  wire s_cal     = is_str & (hold_code == STR_CAL);
  wire s_tx      = is_str & (hold_code == STR_TX);
  wire s_idle    = is_str & (hold_code == STR_IDLE);
  wire s_pwd     = is_str & (hold_code == STR_PWD);
  wire s_ftx     = is_str & (hold_code == STR_FTX);

  txrsc_state_t state;
  txrsc_state_t next_state;
  logic [15:0]  cnt;
  logic [15:0]  next_cnt;
  logic         to_tx;
  logic         next_to_tx;
  logic         released;
  logic         next_released;
  logic         next_pre;
  logic [1:0]   fourth;
  logic [1:0]   next_fourth;
  logic         fifo_empty;

  // Calibration length for the present configuration
  function automatic logic [15:0] cal_len(input logic [7:0] t, input logic [1:0] cp);
    if (t == CAL_TEST_0B) begin
      cal_len = (cp == CP_CAL_OFF) ? CAL_0B_CP_OFF : CAL_0B_CP_ON;
    end else begin
      cal_len = (cp == CP_CAL_OFF) ? CAL_09_CP_OFF : CAL_09_CP_ON;
    end
  endfunction : cal_len

  // Transition lengths
  wire [15:0] cal_w    = cal_len(calibration_test_value_in, charge_pump_cal_enable_in);
  wire        is_ook   = (power_index_select_in == PWR_IDX_OOK);
  wire [15:0] qsym     = {2'b00, symbol_cycles_in[15:2]};
  wire [15:0] esym     = is_ook ? {3'b000, symbol_cycles_in[15:3]} : 16'h0000;
  wire        cal_end  = (auto_calibration_policy_in == POL_FROM_TX) |
                         ((auto_calibration_policy_in == POL_FOURTH) & (fourth == 2'h3));
  wire [15:0] end_len  = qsym + esym + (cal_end ? cal_w : 16'h0000);
  wire [15:0] end_cnt  = (end_len == 16'h0000) ? 16'h0000 : end_len - 16'h0001;
  wire [15:0] set_cnt  = (auto_calibration_policy_in == POL_TO_TX) ?
                         SET_CAL_BASE + cal_w - 16'h0001 : SET_PLAIN - 16'h0001;
  wire [15:0] man_cnt  = MAN_CAL_BASE + cal_w - 16'h0001;
  wire        done     = (cnt == 16'h0000);
  wire        pw_state = (state == ST_CRYSTAL_OFF_STATE) | (state == ST_SLEEP);
  wire        uflow_hit = (state == ST_TX) & mod_byte_req_in & fifo_empty;
  wire        fifo_rd  = (state == ST_TX) & mod_byte_req_in;
  wire        fifo_flush = s_res | (s_ftx & ((state == ST_IDLE) | (state == ST_UFLOW)));

  // Next-state logic; idle and reset strobes override everything
  always_comb begin
    next_state  = state;
    next_cnt    = done ? cnt : cnt - 16'h0001;
    next_to_tx  = to_tx;
    next_pre    = 1'b0;
    next_fourth = fourth;
    if (s_res || s_idle) begin
      next_state = ST_IDLE;
      next_cnt   = 16'h0000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (s_crystal_off_state) begin
            next_state = ST_CRYSTAL_OFF_STATE;
          end else if (s_pwd) begin
            next_state = ST_SLEEP;
          end else if (s_cal) begin
            next_state = ST_CAL;
            next_cnt   = man_cnt;
          end else if (s_tx || s_synth_on_tx_freq_state) begin
            next_state = ST_SETTLE;
            next_cnt   = set_cnt;
            next_to_tx = s_tx;
          end
        end
        ST_CRYSTAL_OFF_STATE, ST_SLEEP: begin
          if (released && !cs_n_s) begin
            next_state = ST_WAKE;
            next_cnt   = WAKE_CYC - 16'h0001;
          end
        end
        ST_WAKE, ST_CAL, ST_TXEND: begin
          if (done) begin
            next_state = ST_IDLE;
          end
        end
        ST_SETTLE: begin
          if (done) begin
            next_state = to_tx ? ST_TX : ST_SYNTH_ON_TX_FREQ_STATE;
            next_pre   = to_tx;
          end
        end
        ST_SYNTH_ON_TX_FREQ_STATE: begin
          if (s_tx) begin
            next_state = ST_TX;
            next_pre   = 1'b1;
          end
        end
        ST_TX: begin
          if (uflow_hit) begin
            next_state = ST_UFLOW;
          end else if (packet_done_in) begin
            if (after_transmit_state_in == AFT_SYNTH_ON_TX_FREQ_STATE) begin
              next_state = ST_SYNTH_ON_TX_FREQ_STATE;
            end else if (after_transmit_state_in == AFT_TX) begin
              next_pre = 1'b1;
            end else begin
              next_state  = ST_TXEND;
              next_cnt    = end_cnt;
              next_fourth = fourth + 2'h1;
            end
          end
        end
        ST_UFLOW: begin
          if (s_ftx) begin
            next_state = ST_IDLE;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // Crystal stops only once chip-select has been released in a low-power state
  assign next_released = ((next_state == ST_CRYSTAL_OFF_STATE) | (next_state == ST_SLEEP)) &
                         (released | cs_n_s);

  // Controller registers; reset behaves as a power-on wake
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state    <= ST_WAKE;
      cnt      <= WAKE_CYC - 16'h0001;
      to_tx    <= 1'b0;
      released <= 1'b0;
      fourth   <= 2'h0;
      req_seen <= 1'b0;
      ack      <= 1'b0;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      to_tx    <= next_to_tx;
      released <= next_released;
      fourth   <= next_fourth;
      req_seen <= req_s;
      ack      <= req_s;
    end
  end

  // Registered power and status outputs
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      xosc_enable_out     <= 1'b1;
      core_reg_enable_out <= 1'b1;
      chip_ready_n_out    <= 1'b1;
      tx_active_out       <= 1'b0;
      synth_on_out        <= 1'b0;
      tx_underflow_out    <= 1'b0;
      tx_preamble_out     <= 1'b0;
      fifo_threshold_out  <= 1'b0;
    end else begin
      xosc_enable_out     <= xosc_force_on_in | ~next_released;
      core_reg_enable_out <= ~(next_released & (next_state == ST_SLEEP));
      chip_ready_n_out    <= next_released | (next_state == ST_WAKE);
      tx_active_out       <= (next_state == ST_TX);
      synth_on_out        <= (next_state == ST_SYNTH_ON_TX_FREQ_STATE) | (next_state == ST_TX);
      tx_underflow_out    <= (next_state == ST_UFLOW);
      tx_preamble_out     <= next_pre;
      fifo_threshold_out  <= tx_fill_count_out >= fifo_threshold_sel(fifo_threshold_sel_in);
    end
  end

  // Transmit FIFO; fill count is the status value
  txrsc_fifo u_fifo (
    .clk_in       (mclk_in),
    .resetn_in    (resetn_in),
    .wr_in        (fifo_wr),
    .wr_data_in   (hold_data),
    .flush_in     (fifo_flush),
    .rd_in        (fifo_rd),
    .rd_data_out  (tx_byte_out),
    .rd_valid_out (tx_byte_valid_out),
    .count_out    (tx_fill_count_out),
    .empty_out    (fifo_empty)
  );

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  force_xosc_a: assert property (xosc_force_on_in |=> xosc_enable_out)
    else $error("forced crystal was switched off");
  crystal_off_state_entry_a: assert property ((state == ST_IDLE) && s_crystal_off_state |=> state == ST_CRYSTAL_OFF_STATE)
    else $error("crystal-off strobe not taken in idle");
  crystal_off_state_gate_a: assert property ((state == ST_TX) && s_crystal_off_state |=> state != ST_CRYSTAL_OFF_STATE)
    else $error("crystal-off strobe taken outside idle");
  sleep_power_a: assert property ((state == ST_SLEEP) && released && cs_n_s && !cmd_pulse
    && !xosc_force_on_in |=> !core_reg_enable_out && !xosc_enable_out)
    else $error("sleep did not cut regulator and crystal");
  wake_ready_a: assert property ((state == ST_WAKE) |-> chip_ready_n_out)
    else $error("ready shown during oscillator restart");
  idle_force_a: assert property (s_idle |=> state == ST_IDLE)
    else $error("idle strobe did not force idle");
  settle_plain_a: assert property ((state == ST_IDLE) && s_tx &&
    auto_calibration_policy_in != POL_TO_TX |=> state == ST_SETTLE ##0 cnt == SET_PLAIN - 16'h0001)
    else $error("wrong idle to transmit length");
  underflow_a: assert property (uflow_hit && !cmd_pulse |=> state == ST_UFLOW)
    else $error("underflow not detected");
  tx_end_a: assert property ((state == ST_TXEND) && done && !cmd_pulse |=> state == ST_IDLE)
    else $error("transmit end did not reach idle");
  thr_flag_a: assert property (1'b1 |=> fifo_threshold_out ==
    ($past(tx_fill_count_out) >= fifo_threshold_sel($past(fifo_threshold_sel_in))))
    else $error("threshold flag disagrees with fill");
endmodule : txrsc_ctrl
`default_nettype wire

// file: verif/txrsc_host.sv
// Host model: offers strobes and FIFO bytes over the link
`timescale 1ns/10ps
`default_nettype none
module txrsc_host (
  // Free link clock, gated link clock and handshake
  input  wire logic       lclk_raw_in,
  input  wire logic       link_clk_in,
  input  wire logic       link_busy_in,
  // Link request lines
  output var  logic       link_run_out,
  output var  logic       link_valid_out,
  output var  logic       link_is_byte_out,
  output var  logic [2:0] link_strobe_out,
  output var  logic [7:0] link_data_out
);
  // Idle lines at time zero
  initial begin
    link_run_out     = 1'b0;
    link_valid_out   = 1'b0;
    link_is_byte_out = 1'b0;
    link_strobe_out  = 3'h0;
    link_data_out    = 8'h00;
  end

  // One command per frame; clock stands still between frames
  task automatic send(input logic is_byte, input logic [2:0] code, input logic [7:0] data);
    int n;
    @(negedge lclk_raw_in);
    link_run_out = 1'b1;
    @(posedge link_clk_in);
    #2;
    link_valid_out   = 1'b1;
    link_is_byte_out = is_byte;
    link_strobe_out  = code;
    link_data_out    = data;
    @(posedge link_clk_in);
    #2;
    link_valid_out  = 1'b0;
    link_strobe_out = ~code; // Released lines carry no stale value
    link_data_out   = ~data;
    n = 0;
    while (link_busy_in !== 1'b1 && n < 4) begin
      @(posedge link_clk_in);
      n++;
    end
    n = 0;
    while (link_busy_in !== 1'b0 && n < 40) begin
      @(posedge link_clk_in);
      n++;
    end
    @(negedge lclk_raw_in);
    link_run_out = 1'b0;
  endtask : send
endmodule : txrsc_host
`default_nettype wire

// file: verif/txrsc_ctrl_tb.sv
// Self-checking bench for the transmit radio state control
`timescale 1ns/10ps
`default_nettype none
module txrsc_ctrl_tb;
  import txrsc_pkg::*;
  // Bench signals
  logic mclk, lclk_raw, lclk, run, resetn, valid, is_byte, busy, chip_select_n, force_on;
  logic req, done, tx_valid, preamble, xosc, core_reg, ready_n;
  logic tx_act, synth, uflow, thr_flag, pre_seen;
  logic [2:0] strobe, pwr;
  logic [7:0] data, test_val, tx_byte;
  logic [1:0] policy, after, cp_en;
  logic [3:0] thr_sel;
  logic [15:0] sym;
  logic [6:0] fill;
  logic [31:0] lfsr;
  logic [7:0] exp_q[$];
  logic [4:0] thr_tab[4] = '{5'h1D, 5'h1A, 5'h1F, 5'h00}; // Selector and expected flag
  int fails, check_count, t;

  // Clocks; link phase unrelated to crystal
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    lclk_raw = 1'b0;
    #7;
    forever #32 lclk_raw = ~lclk_raw;
  end
  assign lclk = lclk_raw & run;

  txrsc_ctrl #(.CAL_09_CP_ON(16'h00C8), .CAL_0B_CP_ON(16'h012C)) dut_u (
    .mclk_in(mclk), .resetn_in(resetn), .link_clk_in(lclk), .link_valid_in(valid),
    .link_is_byte_in(is_byte), .link_strobe_in(strobe), .link_data_in(data),
    .link_busy_out(busy), .chip_select_n_in(chip_select_n), .xosc_force_on_in(force_on),
    .auto_calibration_policy_in(policy), .after_transmit_state_in(after),
    .calibration_test_value_in(test_val), .charge_pump_cal_enable_in(cp_en),
    .power_index_select_in(pwr), .fifo_threshold_sel_in(thr_sel), .symbol_cycles_in(sym),
    .mod_byte_req_in(req), .packet_done_in(done), .tx_byte_out(tx_byte),
    .tx_byte_valid_out(tx_valid), .tx_preamble_out(preamble), .xosc_enable_out(xosc),
    .core_reg_enable_out(core_reg), .chip_ready_n_out(ready_n), .tx_active_out(tx_act),
    .synth_on_out(synth), .tx_underflow_out(uflow), .tx_fill_count_out(fill),
    .fifo_threshold_out(thr_flag));

  txrsc_host host_u (
    .lclk_raw_in(lclk_raw), .link_clk_in(lclk), .link_busy_in(busy), .link_run_out(run),
    .link_valid_out(valid), .link_is_byte_out(is_byte), .link_strobe_out(strobe),
    .link_data_out(data));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  function automatic logic [31:0] next_rand(input logic [31:0] v);
    next_rand = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : next_rand

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : cyc

  // Wait for ready low; host stays off the link until then
  task automatic wait_ready();
    t = 0;
    cyc(3);
    while (ready_n !== 1'b0 && t < 100) begin
      cyc(1);
      t++;
    end
    check("ready after wake", 1, t > 55 && t < 70);
  endtask : wait_ready

  // Sync jitter on the link side allows a small window only
  task automatic settle(input int exp, input string what);
    int n;
    pre_seen = 1'b0;
    n = 0;
    fork
      host_u.send(1'b0, STR_TX, 8'h00);
      begin
        wait (busy === 1'b1);
        while (tx_act !== 1'b1 && n < 30000) begin
          cyc(1);
          n++;
        end
      end
    join
    check(what, 1, n >= exp && n <= exp + 8);
    // Preamble flag is only caught on the falling edge during the pulse
    cyc(1);
    check("preamble", 1, pre_seen);
  endtask : settle

  // Each byte handed out is compared with the oldest note
  always @(negedge mclk) begin
    if (preamble === 1'b1)
      pre_seen = 1'b1;
    if (tx_valid === 1'b1) begin
      if (exp_q.size() == 0)
        check("unexpected byte", 0, 1);
      else
        check("tx byte", exp_q.pop_front(), tx_byte);
    end
  end

  // Watchdog
  initial begin
    #(40000 * 50);
    fails++;
    final_report();
  end

  initial begin
    resetn = 1'b0;
    {chip_select_n, force_on, req, done, pre_seen} = 5'h00;
    {policy, after, cp_en, pwr, thr_sel} = 13'h0000;
    test_val = 8'h09;
    sym = 16'h0020;
    lfsr = 32'h7FBF;
    fails = 0;
    check_count = 0;
    cyc(8);
    check("xosc in reset", 1, xosc);
    check("regulator in reset", 1, core_reg);
    resetn = 1'b1;
    wait_ready();
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      lfsr = next_rand(lfsr);
      exp_q.push_back(lfsr[7:0]);
      host_u.send(1'b1, 3'h0, lfsr[7:0]);
    end
    cyc(4);
    check("fill count", 6, fill);
    foreach (thr_tab[i]) begin
      thr_sel = thr_tab[i][4:1];
      cyc(3);
      check("threshold flag", thr_tab[i][0], thr_flag);
    end
    $display("test fifo done");
    settle(1954, "settle plain");
    host_u.send(1'b0, 3'h2, 8'h00); // Crystal-off code, refused outside idle
    cyc(4);
    check("xosc kept in tx", 1, xosc);
    repeat (6) begin
      req = 1'b1;
      cyc(1);
      req = 1'b0;
      cyc(2);
    end
    check("fifo drained", 0, fill);
    check("all bytes out", 0, exp_q.size());
    after = 2'h1; // Synth-on destination
    done = 1'b1;
    cyc(1);
    done = 1'b0;
    cyc(40);
    check("tx left", 0, tx_act);
    check("synth kept on", 1, synth);
    host_u.send(1'b0, STR_IDLE, 8'h00);
    cyc(6);
    check("idle synth off", 0, synth);
    $display("test tx done");
    test_val = CAL_TEST_0B;
    cp_en = 2'h2;
    policy = POL_TO_TX;
    after = AFT_IDLE;
    settle(1953 + 300, "settle cal");
    req = 1'b1;
    cyc(1);
    req = 1'b0;
    cyc(4);
    check("underflow", 1, uflow);
    host_u.send(1'b0, STR_IDLE, 8'h00);
    cyc(6);
    check("underflow cleared", 0, uflow);
    $display("test calibrated tx done");
    // Synth-on first, then transmit from it without another settle
    policy = POL_NEVER;
    host_u.send(1'b0, STR_SYNTH_ON_TX_FREQ_STATE, 8'h00);
    cyc(1960);
    check("synth-on reached", 1, synth);
    check("synth-on not tx", 0, tx_act);
    pre_seen = 1'b0;
    host_u.send(1'b0, STR_TX, 8'h00);
    cyc(2);
    check("tx from synth-on", 1, tx_act);
    check("preamble from synth-on", 1, pre_seen);
    after = AFT_TX;
    pre_seen = 1'b0;
    done = 1'b1;
    cyc(1);
    done = 1'b0;
    cyc(2);
    check("tx again", 1, tx_act);
    check("preamble again", 1, pre_seen);
    // Idle strobe exit must not calibrate, so a new transmit is taken at once
    policy = POL_FROM_TX;
    host_u.send(1'b0, STR_IDLE, 8'h00);
    cyc(2);
    check("idle from tx", 0, tx_act);
    settle(1954, "settle after idle exit");
    // Automatic exit calibrates; a transmit strobe meanwhile is refused
    after = AFT_IDLE;
    test_val = 8'h09;
    cp_en = CP_CAL_OFF;
    done = 1'b1;
    cyc(1);
    done = 1'b0;
    cyc(3700);
    host_u.send(1'b0, STR_TX, 8'h00);
    cyc(1960);
    check("tx refused in end cal", 0, tx_act);
    host_u.send(1'b0, STR_CAL, 8'h00);
    host_u.send(1'b0, STR_TX, 8'h00);
    cyc(1960);
    check("tx refused in manual cal", 0, tx_act);
    cyc(2200);
    host_u.send(1'b1, 3'h0, lfsr[15:8]);
    host_u.send(1'b1, 3'h0, lfsr[23:16]);
    cyc(4);
    check("fill before flush", 2, fill);
    host_u.send(1'b0, STR_FTX, 8'h00);
    cyc(4);
    check("fill after flush", 0, fill);
    host_u.send(1'b1, 3'h0, lfsr[7:0]);
    host_u.send(1'b0, STR_RES, 8'h00);
    cyc(4);
    check("fill after reset strobe", 0, fill);
    $display("test strobes done");
    host_u.send(1'b0, 3'h2, 8'h00); // Crystal-off code
    cyc(1);
    chip_select_n = 1'b1;
    cyc(6);
    check("xosc off", 0, xosc);
    chip_select_n = 1'b0;
    wait_ready();
    check("xosc back", 1, xosc);
    host_u.send(1'b0, STR_PWD, 8'h00);
    cyc(1);
    chip_select_n = 1'b1;
    cyc(6);
    check("regulator off", 0, core_reg);
    chip_select_n = 1'b0;
    wait_ready();
    check("regulator back", 1, core_reg);
    force_on = 1'b1;
    host_u.send(1'b0, STR_PWD, 8'h00);
    cyc(1);
    chip_select_n = 1'b1;
    cyc(6);
    check("forced xosc", 1, xosc);
    chip_select_n = 1'b0;
    wait_ready();
    $display("test power done");
    final_report();
  end
endmodule : txrsc_ctrl_tb
`default_nettype wire
